// ===== core/bfs_pkg.sv
// shared constants and types for the breaker failure supervisor
package bfs_pkg;
    // clock and supervision time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES =
        (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 7;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [TICK_W-1:0] TICK_RST = 7'h00;

    // data widths
    localparam int TIME_W = 24;
    localparam int CUR_W = 16;
    localparam int FREQ_W = 16;
    localparam int GROUP_W = 8;
    localparam int PHASE_N = 3;
    localparam int POS_W = 2;
    localparam logic [TIME_W-1:0] ELAPSED_RST = 24'h000000;

    // position contact bit positions
    localparam int POS_OPEN_BIT = 0;
    localparam int POS_CLOSED_BIT = 1;
    localparam logic [POS_W-1:0] POS_RST = 2'h0;

    // wide-frequency deviation limit in percent
    localparam int FREQ_DEV_PCT = 5;
    localparam int PCT_FULL = 100;

    // supervision scheme codes
    localparam logic [1:0] SCHEME_CURRENT = 2'h0;
    localparam logic [1:0] SCHEME_POSITION = 2'h1;
    localparam logic [1:0] SCHEME_COMBINED = 2'h2;

    // trigger mode codes
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_EXTERNAL = 2'h1;
    localparam logic [1:0] MODE_CURRENT = 2'h2;

    // supervision states
    typedef enum logic [3:0] {
        ST_STANDBY = 4'h1,
        ST_RUNNING = 4'h2,
        ST_REJECTED = 4'h4,
        ST_TRIPPED = 4'h8
    } bf_state_t;
endpackage

// ===== core/pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // shift chain, first stage read only by the second
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            meta <= pin_i;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    // per-bit acceptance when the last two stages agree
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            always_ff @(posedge mclk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    level_o[b] <= 1'b0;
                end else if (stage2[b] == stage3[b]) begin
                    level_o[b] <= stage3[b];
                end
            end
        end
    endgenerate
endmodule

// ===== core/tick_divider.sv
// restartable divider giving a one-cycle microsecond enable
`timescale 1ns/100ps
module tick_divider (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic restart_i,
    output logic tick_o
);
    logic [bfs_pkg::TICK_W-1:0] count;

    // count up one tick period, realigned on restart
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count <= bfs_pkg::TICK_RST;
            tick_o <= 1'b0;
        end else if (restart_i) begin
            count <= bfs_pkg::TICK_RST;
            tick_o <= 1'b0;
        end else if (count == bfs_pkg::TICK_LAST) begin
            count <= bfs_pkg::TICK_RST;
            tick_o <= 1'b1;
        end else begin
            count <= count + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule

// ===== core/breaker_failure_unit.sv
// breaker failure supervision: trigger, timer, scheme check, lock
`timescale 1ns/100ps
module breaker_failure_unit (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [1:0] scheme_i,
    input wire logic [1:0] trig_mode_i,
    input wire logic [bfs_pkg::GROUP_W-1:0] ext_trip_i,
    input wire logic [bfs_pkg::GROUP_W-1:0] cur_trip_i,
    input wire logic extra_trigger_input_a_i,
    input wire logic extra_trigger_input_b_i,
    input wire logic extra_trigger_input_c_i,
    input wire logic [bfs_pkg::CUR_W-1:0] phase_current_a_i,
    input wire logic [bfs_pkg::CUR_W-1:0] phase_current_b_i,
    input wire logic [bfs_pkg::CUR_W-1:0] phase_current_c_i,
    input wire logic [bfs_pkg::CUR_W-1:0] breaker_current_threshold_i,
    input wire logic [bfs_pkg::TIME_W-1:0] failure_supervision_time_i,
    input wire logic pos_open_pin_i,
    input wire logic pos_closed_pin_i,
    input wire logic wide_freq_en_i,
    input wire logic [bfs_pkg::FREQ_W-1:0] freq_meas_i,
    input wire logic [bfs_pkg::FREQ_W-1:0] freq_nom_i,
    input wire logic lock_ack_i,
    output logic standby_o,
    output logic pickup_o,
    output logic rejected_o,
    output logic trip_o,
    output logic lock_o,
    output logic freq_block_o
);
    localparam int DEV_W = bfs_pkg::FREQ_W + 8;

    bfs_pkg::bf_state_t state;
    bfs_pkg::bf_state_t next_state;
    logic [bfs_pkg::POS_W-1:0] pos_pins;
    logic [bfs_pkg::POS_W-1:0] pos_level;
    logic [bfs_pkg::CUR_W-1:0] phase_cur [bfs_pkg::PHASE_N];
    logic [bfs_pkg::PHASE_N-1:0] phase_high;
    logic current_low;
    logic position_open;
    logic [bfs_pkg::FREQ_W-1:0] freq_dev;
    logic freq_bad;
    logic group_trig;
    logic extra_trig;
    logic trig;
    logic current_blocked;
    logic opened;
    logic start;
    logic tick;
    logic [bfs_pkg::TIME_W-1:0] elapsed;
    logic [bfs_pkg::TIME_W-1:0] limit;
    logic expired;

    // breaker contacts come from pins: three-stage synchroniser
    assign pos_pins[bfs_pkg::POS_OPEN_BIT] = pos_open_pin_i;
    assign pos_pins[bfs_pkg::POS_CLOSED_BIT] = pos_closed_pin_i;

    pin_sync #(
        .WIDTH(bfs_pkg::POS_W)
    ) u_pos_sync (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .pin_i(pos_pins),
        .level_o(pos_level)
    );

    // open only when the open contact is made and the closed one is not
    assign position_open = pos_level[bfs_pkg::POS_OPEN_BIT] &
        ~pos_level[bfs_pkg::POS_CLOSED_BIT];

    // per-phase threshold comparison
    assign phase_cur[0] = phase_current_a_i;
    assign phase_cur[1] = phase_current_b_i;
    assign phase_cur[2] = phase_current_c_i;

    genvar p;
    generate
        for (p = 0; p < bfs_pkg::PHASE_N; p++) begin : g_phase
            assign phase_high[p] =
                phase_cur[p] >= breaker_current_threshold_i;
        end
    endgenerate

    assign current_low = ~(|phase_high);

    // frequency deviation from nominal, checked against the percent limit
    assign freq_dev = (freq_meas_i >= freq_nom_i) ?
        freq_meas_i - freq_nom_i : freq_nom_i - freq_meas_i;
    assign freq_bad = wide_freq_en_i &&
        (DEV_W'(freq_dev) * DEV_W'(bfs_pkg::PCT_FULL) >
         DEV_W'(freq_nom_i) * DEV_W'(bfs_pkg::FREQ_DEV_PCT));

    assign current_blocked =
        freq_bad && scheme_i == bfs_pkg::SCHEME_CURRENT;

    // trigger selection by mode plus the three extra inputs
    always_comb begin
        group_trig = 1'b0;
        unique case (trig_mode_i)
            bfs_pkg::MODE_EXTERNAL: group_trig = |ext_trip_i;
            bfs_pkg::MODE_CURRENT: group_trig = |cur_trip_i;
            default: group_trig = 1'b0;
        endcase
    end

    assign extra_trig = extra_trigger_input_a_i |
        extra_trigger_input_b_i | extra_trigger_input_c_i;
    assign trig = group_trig | extra_trig;

    // breaker opening evidence according to the scheme in force
    always_comb begin
        opened = 1'b0;
        unique case (scheme_i)
            bfs_pkg::SCHEME_CURRENT: opened = current_low;
            bfs_pkg::SCHEME_POSITION: opened = position_open;
            bfs_pkg::SCHEME_COMBINED: begin
                if (freq_bad) begin
                    opened = position_open;
                end else begin
                    opened = current_low | position_open;
                end
            end
            default: opened = position_open;
        endcase
    end

    // supervision state transitions
    always_comb begin
        next_state = state;
        unique case (state)
            bfs_pkg::ST_STANDBY: begin
                if (trig && !current_blocked) begin
                    if (opened) begin
                        next_state = bfs_pkg::ST_REJECTED;
                    end else begin
                        next_state = bfs_pkg::ST_RUNNING;
                    end
                end
            end
            bfs_pkg::ST_RUNNING: begin
                if (current_blocked) begin
                    next_state = bfs_pkg::ST_STANDBY;
                end else if (opened) begin
                    if (trig) begin
                        next_state = bfs_pkg::ST_REJECTED;
                    end else begin
                        next_state = bfs_pkg::ST_STANDBY;
                    end
                end else if (expired) begin
                    next_state = bfs_pkg::ST_TRIPPED;
                end
            end
            bfs_pkg::ST_REJECTED: begin
                if (!trig) begin
                    next_state = bfs_pkg::ST_STANDBY;
                end
            end
            bfs_pkg::ST_TRIPPED: begin
                if (!trig) begin
                    next_state = bfs_pkg::ST_STANDBY;
                end
            end
            default: next_state = bfs_pkg::ST_STANDBY;
        endcase
    end

    // state register; running is left only as above, not on trigger drop
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= bfs_pkg::ST_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    assign start = state == bfs_pkg::ST_STANDBY &&
        next_state == bfs_pkg::ST_RUNNING;

    // microsecond base, realigned at start so the delay is exact
    tick_divider u_tick (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .restart_i(start),
        .tick_o(tick)
    );

    // supervision timer: setting latched at start, counts microseconds
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            elapsed <= bfs_pkg::ELAPSED_RST;
            limit <= bfs_pkg::ELAPSED_RST;
        end else if (start) begin
            elapsed <= bfs_pkg::ELAPSED_RST;
            limit <= failure_supervision_time_i;
        end else if (state == bfs_pkg::ST_RUNNING && tick && !expired) begin
            elapsed <= elapsed + 1'b1;
        end
    end

    assign expired = elapsed >= limit;

    // state indications, registered from the next state
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            standby_o <= 1'b1;
            pickup_o <= 1'b0;
            rejected_o <= 1'b0;
            trip_o <= 1'b0;
        end else begin
            standby_o <= next_state == bfs_pkg::ST_STANDBY;
            pickup_o <= next_state == bfs_pkg::ST_RUNNING;
            rejected_o <= next_state == bfs_pkg::ST_REJECTED;
            trip_o <= next_state == bfs_pkg::ST_TRIPPED;
        end
    end

    // lock latch: set with the trip, set wins over acknowledge
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock_o <= 1'b0;
        end else if (next_state == bfs_pkg::ST_TRIPPED &&
                     state != bfs_pkg::ST_TRIPPED) begin
            lock_o <= 1'b1;
        end else if (lock_ack_i) begin
            lock_o <= 1'b0;
        end
    end

    // wide-frequency blocking indication
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            freq_block_o <= 1'b0;
        end else begin
            freq_block_o <= freq_bad;
        end
    end

    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_expire;
        state == bfs_pkg::ST_RUNNING && expired && !opened &&
            !current_blocked;
    endsequence

    sequence s_trip_set;
        trip_o && lock_o;
    endsequence

    property p_expire_trip;
        s_expire |=> s_trip_set;
    endproperty
    a_expire_trip: assert property (p_expire_trip)
        else $error("expiry did not raise trip and lock");

    property p_trip_cause;
        $rose(trip_o) |-> $past(expired) &&
            $past(state) == bfs_pkg::ST_RUNNING;
    endproperty
    a_trip_cause: assert property (p_trip_cause)
        else $error("trip raised without timer expiry");

    property p_lock_hold;
        lock_o && !lock_ack_i && !trip_o |=> lock_o;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock dropped without acknowledge");

    // lock may still stand from an earlier unacknowledged trip
    property p_lock_with_trip;
        $rose(trip_o) |-> lock_o;
    endproperty
    a_lock_with_trip: assert property (p_lock_with_trip)
        else $error("lock not raised with trip");

    property p_keep_running;
        state == bfs_pkg::ST_RUNNING && !opened && !expired &&
            !current_blocked |=> state == bfs_pkg::ST_RUNNING;
    endproperty
    a_keep_running: assert property (p_keep_running)
        else $error("timer stopped without breaker opening");

    property p_stop_open;
        state == bfs_pkg::ST_RUNNING && opened |=>
            !trip_o && state != bfs_pkg::ST_RUNNING;
    endproperty
    a_stop_open: assert property (p_stop_open)
        else $error("timer not stopped on opening");

    property p_reject;
        state == bfs_pkg::ST_RUNNING && opened && trig &&
            !current_blocked |=> rejected_o ##1 (rejected_o || standby_o);
    endproperty
    a_reject: assert property (p_reject)
        else $error("rejected state not entered");

    property p_reject_exit;
        state == bfs_pkg::ST_REJECTED && !trig |=>
            standby_o && !rejected_o;
    endproperty
    a_reject_exit: assert property (p_reject_exit)
        else $error("rejected did not return to stand-by");

    property p_no_pickup;
        state == bfs_pkg::ST_STANDBY && trig && opened |=> !pickup_o;
    endproperty
    a_no_pickup: assert property (p_no_pickup)
        else $error("pickup raised with breaker already open");

    property p_current_high;
        state == bfs_pkg::ST_RUNNING && !freq_bad &&
            scheme_i == bfs_pkg::SCHEME_CURRENT && (|phase_high) |=>
            !standby_o && !rejected_o;
    endproperty
    a_current_high: assert property (p_current_high)
        else $error("timer stopped while current above threshold");

    property p_freq_block;
        state == bfs_pkg::ST_STANDBY && current_blocked |=> !pickup_o;
    endproperty
    a_freq_block: assert property (p_freq_block)
        else $error("current scheme started while frequency off");

    property p_extra_start;
        state == bfs_pkg::ST_STANDBY && extra_trig && !opened &&
            !current_blocked |=> pickup_o;
    endproperty
    a_extra_start: assert property (p_extra_start)
        else $error("extra trigger did not start supervision");
endmodule

// ===== test/breaker_model.sv
// breaker contacts and phase current sources seen by the supervisor
`timescale 1ns/100ps
module breaker_model (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic open_cmd_i,
    input wire logic jam_cur_i,
    input wire logic jam_pos_i,
    input wire logic [15:0] load_i,
    output logic pos_open_o,
    output logic pos_closed_o,
    output logic [15:0] cur_a_o,
    output logic [15:0] cur_b_o,
    output logic [15:0] cur_c_o
);
    // main contacts need a travel time before they part
    localparam int TRAVEL = 30;
    int travel;
    logic opened;

    // travel counter, reclose is instant when the command drops
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            travel <= 0;
        end else if (!open_cmd_i) begin
            travel <= 0;
        end else if (travel < TRAVEL) begin
            travel <= travel + 1;
        end
    end

    // jammed contacts or a jammed current path hide the opening
    assign opened = (travel == TRAVEL);
    assign pos_open_o = opened && !jam_pos_i;
    assign pos_closed_o = !pos_open_o;
    assign cur_a_o = (opened && !jam_cur_i) ? 16'h0000 : load_i;
    assign cur_b_o = cur_a_o >> 1;
    assign cur_c_o = cur_a_o >> 2;
endmodule

// ===== test/testbench.sv
// self-checking bench for the breaker failure supervisor
`timescale 1ns/100ps
module testbench;
    localparam int SUP_US = 2;
    // start edge, tick realign and registered trip add three samples
    localparam int TRIP_N = SUP_US * bfs_pkg::TICK_CYCLES + 3;
    localparam logic [15:0] LOAD = 16'h0200;
    logic mclk_i;
    logic arst_n_i;
    logic [1:0] scheme;
    logic [1:0] trig_mode;
    logic [bfs_pkg::GROUP_W-1:0] ext_trip;
    logic [bfs_pkg::GROUP_W-1:0] cur_trip;
    logic [2:0] extra;
    logic [15:0] cur_a;
    logic [15:0] cur_b;
    logic [15:0] cur_c;
    logic [15:0] threshold;
    logic [23:0] sup_time;
    logic pos_open;
    logic pos_closed;
    logic wide_en;
    logic [15:0] f_meas;
    logic [15:0] f_nom;
    logic lock_ack;
    logic standby;
    logic pickup;
    logic rejected;
    logic trip;
    logic lock;
    logic freq_block;
    logic brk_cmd;
    logic jam_cur;
    logic jam_pos;
    logic seen;
    logic want;
    int n_mismatch;
    int tests_run;

    breaker_model brk (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .open_cmd_i(brk_cmd), .jam_cur_i(jam_cur), .jam_pos_i(jam_pos),
        .load_i(LOAD), .pos_open_o(pos_open), .pos_closed_o(pos_closed),
        .cur_a_o(cur_a), .cur_b_o(cur_b), .cur_c_o(cur_c));

    breaker_failure_unit dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .scheme_i(scheme), .trig_mode_i(trig_mode), .ext_trip_i(ext_trip),
        .cur_trip_i(cur_trip), .extra_trigger_input_a_i(extra[0]),
        .extra_trigger_input_b_i(extra[1]),
        .extra_trigger_input_c_i(extra[2]),
        .phase_current_a_i(cur_a), .phase_current_b_i(cur_b),
        .phase_current_c_i(cur_c), .breaker_current_threshold_i(threshold),
        .failure_supervision_time_i(sup_time), .pos_open_pin_i(pos_open),
        .pos_closed_pin_i(pos_closed), .wide_freq_en_i(wide_en),
        .freq_meas_i(f_meas), .freq_nom_i(f_nom), .lock_ack_i(lock_ack),
        .standby_o(standby), .pickup_o(pickup), .rejected_o(rejected),
        .trip_o(trip), .lock_o(lock), .freq_block_o(freq_block));

    // final counts and verdict
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected bit at %0t: %b not %b", $time, got, exp);
        end
    endtask

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected value at %0t: %0d not %0d", $time, got, exp);
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge mclk_i);
    endtask

    // short external trip, breaker told to open; exp is trip cycle or 0
    task automatic run_case(input logic [1:0] sch, input logic jc,
                            input logic jp, input int exp);
        int got;
        got = 0;
        scheme = sch;
        jam_cur = jc;
        jam_pos = jp;
        cycles(6);
        ext_trip = 8'h04;
        brk_cmd = 1'b1;
        for (int n = 1; n <= TRIP_N + 58; n++) begin
            @(negedge mclk_i);
            if (n == 3) begin
                ext_trip = 8'h00;
            end
            if (trip === 1'b1 && got == 0) begin
                got = n;
                check_bit(lock, 1'b1);
            end
        end
        check_val(32'(got), 32'(exp));
        check_bit(lock, exp != 0);
        lock_ack = 1'b1;
        cycles(1);
        lock_ack = 1'b0;
        brk_cmd = 1'b0;
        cycles(8);
        check_bit(lock, 1'b0);
        check_bit(standby, 1'b1);
    endtask

    // free-running clock
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        $display("unexpected hang at %0t: run took too long", $time);
        test_done();
    end

    // main sequence
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        arst_n_i = 1'b0;
        scheme = bfs_pkg::SCHEME_CURRENT;
        trig_mode = bfs_pkg::MODE_EXTERNAL;
        ext_trip = 8'h00;
        cur_trip = 8'h00;
        extra = 3'h0;
        threshold = LOAD;
        sup_time = 24'(SUP_US);
        wide_en = 1'b0;
        f_nom = 16'h03e8;
        f_meas = 16'h03e8;
        lock_ack = 1'b0;
        brk_cmd = 1'b0;
        jam_cur = 1'b0;
        jam_pos = 1'b0;
        cycles(2);
        check_bit(standby, 1'b1);
        check_bit(pickup | rejected | trip | lock, 1'b0);
        arst_n_i = 1'b1;
        cycles(6);
        // current scheme against a jammed current path, position and combined against each kind of breaker misbehaviour
        run_case(bfs_pkg::SCHEME_CURRENT, 1'b0, 1'b0, 0);
        run_case(bfs_pkg::SCHEME_CURRENT, 1'b1, 1'b0, TRIP_N);
        run_case(bfs_pkg::SCHEME_POSITION, 1'b1, 1'b0, 0);
        run_case(bfs_pkg::SCHEME_POSITION, 1'b0, 1'b1, TRIP_N);
        // unused scheme code falls back to position supervision
        run_case(2'h3, 1'b1, 1'b0, 0);
        run_case(bfs_pkg::SCHEME_COMBINED, 1'b1, 1'b0, 0);
        run_case(bfs_pkg::SCHEME_COMBINED, 1'b0, 1'b1, 0);
        run_case(bfs_pkg::SCHEME_COMBINED, 1'b1, 1'b1, TRIP_N);
        // current one step under the threshold counts as opened
        threshold = LOAD + 16'h0001;
        run_case(bfs_pkg::SCHEME_CURRENT, 1'b1, 1'b1, 0);
        threshold = LOAD;
        // frequency deviation at and past the limit
        wide_en = 1'b1;
        f_meas = 16'h041a;
        cycles(3);
        check_bit(freq_block, 1'b0);
        f_meas = 16'h041b;
        cycles(3);
        check_bit(freq_block, 1'b1);
        run_case(bfs_pkg::SCHEME_CURRENT, 1'b1, 1'b1, 0);
        run_case(bfs_pkg::SCHEME_COMBINED, 1'b0, 1'b1, TRIP_N);
        wide_en = 1'b0;
        // breaker opens while the trigger is still held
        scheme = bfs_pkg::SCHEME_POSITION;
        jam_cur = 1'b0;
        jam_pos = 1'b0;
        ext_trip = 8'h80;
        brk_cmd = 1'b1;
        cycles(100);
        check_bit(rejected, 1'b1);
        check_bit(trip, 1'b0);
        ext_trip = 8'h00;
        cycles(1);
        check_bit(rejected, 1'b0);
        check_bit(standby, 1'b1);
        // already open and no current: current scheme must not pick up
        scheme = bfs_pkg::SCHEME_CURRENT;
        extra = 3'h1;
        seen = 1'b0;
        repeat (10) begin
            @(negedge mclk_i);
            seen = seen | pickup;
        end
        check_bit(seen, 1'b0);
        extra = 3'h0;
        brk_cmd = 1'b0;
        cycles(8);
        // every trigger source under every mode, zero supervision time
        sup_time = 24'h000000;
        scheme = bfs_pkg::SCHEME_POSITION;
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 5; s++) begin
                trig_mode = 2'(m);
                if (s == 0) begin
                    ext_trip = 8'h10;
                end else if (s == 1) begin
                    cur_trip = 8'h02;
                end else begin
                    extra = 3'(1 << (s - 2));
                end
                @(negedge mclk_i);
                want = (s > 1) || (m == 1 && s == 0) || (m == 2 && s == 1);
                check_bit(pickup, want);
                ext_trip = 8'h00;
                cur_trip = 8'h00;
                extra = 3'h0;
                cycles(4);
                lock_ack = 1'b1;
                cycles(1);
                lock_ack = 1'b0;
                cycles(2);
                check_bit(standby, 1'b1);
            end
        end
        test_done();
    end
endmodule
